// ### logic/vecarb_map.vh
// constants for the vector-select arbiter
`ifndef VECARB_MAP_VH
`define VECARB_MAP_VH
`define VA_SLOT_TRAP 8'hFE
`define VA_SLOT_NMI 8'hFC
`define VA_SLOT_EXT 8'hFA
`define VA_SLOT_IDLE 8'hF8
`define VA_SLOT_T1A 8'hF6
`define VA_SLOT_T1B 8'hF4
`define VA_SLOT_SER 8'hF2
`define VA_SLOT_TWB 8'hF0
`define VA_SLOT_PORT 8'hE2
`define VA_SLOT_DEF 8'hE0
`define VA_PAGE_LAST 8'hFF
`define VA_ACK_PC 15'h00FF
`define VA_ACK_CYCLES 3'h7
`define VA_PC_RST 15'h0000
`define VA_NSRC 7
`endif

// ### logic/vecarb_prio.v
// fixed-rank priority encoder producing the vector slot offset
`include "vecarb_map.vh"
module vecarb_prio (
   input wire trap_pend,
   input wire [`VA_NSRC-1:0] active,
   output reg [7:0] slot
);
   // active bit order: 6 ext,5 idle,4 t1a,3 t1b,2 ser,1 twb,0 port
   always @* begin
      if (trap_pend)
         slot = `VA_SLOT_TRAP;
      else if (active[6])
         slot = `VA_SLOT_EXT;
      else if (active[5])
         slot = `VA_SLOT_IDLE;
      else if (active[4])
         slot = `VA_SLOT_T1A;
      else if (active[3])
         slot = `VA_SLOT_T1B;
      else if (active[2])
         slot = `VA_SLOT_SER;
      else if (active[1])
         slot = `VA_SLOT_TWB;
      else if (active[0])
         slot = `VA_SLOT_PORT;
      else
         slot = `VA_SLOT_DEF;
   end
endmodule

// ### logic/vecarb_top.v
// vector-select arbitration, vector fetch and interrupt acknowledge
`include "vecarb_map.vh"
module vecarb_top (
   clk,
   rst_n,
   vector_select_instruction,
   trap_opcode,
   clear_trap_pending_instruction,
   irq_ack,
   gie_set,
   instr_pc,
   src_enable,
   src_pending,
   pmem_data,
   pmem_addr,
   pmem_rd,
   pc_load,
   pc_value,
   push,
   push_addr,
   global_interrupt_enable,
   trap_pending,
   busy
);
   input wire clk;
   input wire rst_n;
   input wire vector_select_instruction;
   input wire trap_opcode;
   input wire clear_trap_pending_instruction;
   input wire irq_ack;
   input wire gie_set;
   input wire [14:0] instr_pc;
   input wire [`VA_NSRC-1:0] src_enable;
   input wire [`VA_NSRC-1:0] src_pending;
   input wire [7:0] pmem_data;
   output reg [14:0] pmem_addr;
   output reg pmem_rd;
   output reg pc_load;
   output reg [14:0] pc_value;
   output reg push;
   output reg [14:0] push_addr;
   output reg global_interrupt_enable;
   output reg trap_pending;
   output wire busy;

   localparam ST_IDLE = 3'h0;
   localparam ST_RDHI = 3'h1;
   localparam ST_RDLO = 3'h2;
   localparam ST_LOAD = 3'h3;
   localparam ST_ACK = 3'h4;

   reg rst_s1_q;
   reg rst_s2_q;
   wire rst_i_n;
   reg [2:0] st_q;
   reg [2:0] cnt_q;
   reg [14:0] tab_q;
   reg [6:0] hi_q;
   wire [7:0] slot;
   wire [`VA_NSRC-1:0] active;
   wire [6:0] page_next;
   reg [2:0] st_d;
   reg [2:0] cnt_d;
   reg [14:0] tab_d;
   wire vs_go;
   wire ack_go;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_i_n = rst_s2_q;

   assign active = src_enable & src_pending;

   vecarb_prio u_prio (
      .trap_pend(trap_pending),
      .active(active),
      .slot(slot)
   );

   // page of the table: next page when instruction is at the page top
   assign page_next = instr_pc[14:8] + 7'h01;
   assign busy = (st_q != ST_IDLE);
   assign vs_go = (st_q == ST_IDLE) && vector_select_instruction;
   assign ack_go = (st_q == ST_IDLE) && !vector_select_instruction && irq_ack;

   always @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         trap_pending <= 1'b0;
      end else if (trap_opcode) begin
         trap_pending <= 1'b1; // set wins over clear
      end else if (clear_trap_pending_instruction) begin
         trap_pending <= 1'b0;
      end
   end

   // next state of the fetch and acknowledge sequencer
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (vector_select_instruction)
               st_d = ST_RDHI;
            else if (irq_ack)
               st_d = ST_ACK;
         end
         ST_RDHI: st_d = ST_RDLO;
         ST_RDLO: st_d = ST_LOAD;
         ST_LOAD: st_d = ST_IDLE;
         ST_ACK: begin
            if (cnt_q == 3'h1)
               st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // table address: slot replaces the low byte only
   always @* begin
      if (instr_pc[7:0] == `VA_PAGE_LAST)
         tab_d = {page_next, slot};
      else
         tab_d = {instr_pc[14:8], slot};
   end

   // acknowledge cycle counter
   always @* begin
      cnt_d = cnt_q;
      if (ack_go)
         cnt_d = `VA_ACK_CYCLES - 3'h1;
      else if (st_q == ST_ACK)
         cnt_d = cnt_q - 3'h1;
   end

   always @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         st_q <= ST_IDLE;
         cnt_q <= 3'h0;
         tab_q <= `VA_PC_RST;
         hi_q <= 7'h00;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         // sources sampled in the first cycle of the instruction
         if (vs_go)
            tab_q <= tab_d;
         if (st_q == ST_RDLO)
            hi_q <= pmem_data[6:0];
      end
   end

   // global enable: acknowledge clears it, return-from-interrupt sets it
   always @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n)
         global_interrupt_enable <= 1'b0;
      else if (ack_go)
         global_interrupt_enable <= 1'b0;
      else if (gie_set)
         global_interrupt_enable <= 1'b1;
   end

   always @(posedge clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pmem_addr <= `VA_PC_RST;
         pmem_rd <= 1'b0;
         pc_load <= 1'b0;
         pc_value <= `VA_PC_RST;
         push <= 1'b0;
         push_addr <= `VA_PC_RST;
      end else begin
         pmem_rd <= 1'b0;
         pc_load <= 1'b0;
         push <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (ack_go) begin
                  push <= 1'b1;
                  push_addr <= instr_pc;
               end
            end
            ST_RDHI: begin
               pmem_addr <= tab_q;
               pmem_rd <= 1'b1;
            end
            ST_RDLO: begin
               pmem_addr <= {tab_q[14:1], 1'b1};
               pmem_rd <= 1'b1;
            end
            ST_LOAD: begin
               pc_value <= {hi_q, pmem_data};
               pc_load <= 1'b1;
            end
            ST_ACK: begin
               if (cnt_q == 3'h1) begin
                  pc_value <= `VA_ACK_PC;
                  pc_load <= 1'b1;
               end
            end
            default: pc_load <= 1'b0;
         endcase
      end
   end
endmodule

// ### tb/vecarb_pmem.sv
// program memory model answering the vector fetch
module vecarb_pmem (
   input logic pmem_rd,
   input logic [14:0] pmem_addr,
   output logic [7:0] pmem_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] d;
   // data stands while the strobe is high, inverted otherwise
   assign d = pmem_addr[7:0] ^ {1'b0, pmem_addr[14:8]};
   assign pmem_data = pmem_rd ? d : ~d;
endmodule

// ### tb/vecarb_checker.sv
// assertions on the vector-select arbiter ports
module vecarb_checker (
   input logic clk, rst_n, vector_select_instruction, irq_ack, pmem_rd,
   input logic pc_load, push, global_interrupt_enable, trap_pending, busy,
   input logic trap_opcode,
   input logic [14:0] instr_pc, pmem_addr, pc_value,
   input logic [6:0] src_enable, src_pending
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire go = vector_select_instruction && !busy;
   wire act = |(src_enable & src_pending);
   sequence fetch_s; !pmem_rd ##1 pmem_rd ##1 pmem_rd ##1 pc_load; endsequence
   sequence ack_s; push && !global_interrupt_enable ##6 pc_load; endsequence
   sel_walk_a: assert property (go |=> fetch_s)
      else $error("vector fetch steps wrong");
   vec_pair_a: assert property (pmem_rd && $past(pmem_rd) |->
      pmem_addr == $past(pmem_addr) + 15'h1) else $error("pair addr");
   table_page_a: assert property (go |-> ##2
      pmem_addr[14:8] == $past(instr_pc[14:8], 2) +
      {6'h00, $past(instr_pc[7:0], 2) == 8'hFF})
      else $error("table page wrong");
   trap_slot_a: assert property (go && trap_pending |-> ##2
      pmem_addr[7:0] == 8'hFE) else $error("trap slot");
   default_slot_a: assert property (go && !trap_pending && !act
      |-> ##2 pmem_addr[7:0] == 8'hE0) else $error("default slot");
   ext_slot_a: assert property (go && !trap_pending &&
      src_enable[6] && src_pending[6] |-> ##2 pmem_addr[7:0] == 8'hFA)
      else $error("ext slot");
   ack_seq_a: assert property (irq_ack && !busy &&
      !vector_select_instruction |=> ack_s ##0 pc_value == 15'h00FF)
      else $error("acknowledge steps wrong");
   trap_flag_a: assert property (trap_opcode |=> trap_pending)
      else $error("trap flag not set");
endmodule
bind vecarb_top vecarb_checker u_chk (.*);

// ### tb/tb.sv
// testbench for the vector-select arbiter
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, vector_select_instruction = 0, irq_ack = 0;
   logic trap_opcode = 0, clear_trap_pending_instruction = 0, gie_set = 0;
   logic pmem_rd, pc_load, push, global_interrupt_enable, trap_pending, busy;
   logic [14:0] instr_pc = '0, pmem_addr, pc_value, push_addr;
   logic [6:0] src_enable = '0, src_pending = '0;
   logic [7:0] pmem_data;
   int n_fail = 0, n_checks = 0;
   // rows: instruction address, enables, pendings, winning slot
   logic [36:0] rows [9] = '{{15'h0100, 7'h7F, 7'h00, 8'hE0},
      {15'h0120, 7'h00, 7'h7F, 8'hE0}, {15'h00FF, 7'h7F, 7'h7F, 8'hFA},
      {15'h0210, 7'h3F, 7'h3F, 8'hF8}, {15'h03DF, 7'h1F, 7'h3F, 8'hF6},
      {15'h04FE, 7'h0F, 7'h0F, 8'hF4}, {15'h0500, 7'h27, 7'h57, 8'hF2},
      {15'h06FF, 7'h03, 7'h03, 8'hF0}, {15'h7E00, 7'h01, 7'h01, 8'hE2}};
   vecarb_top u_vecarb_top (.*);
   vecarb_pmem u_vecarb_pmem (.*);
   always #5 clk = ~clk;
   task automatic chk(input string n, input logic [14:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wt();
      int k;
      k = 0;
      while (pc_load !== 1'b1 && k < 12) begin
         @(negedge clk);
         k++;
      end
      chk("pc_load", pc_load, 15'h1);
      @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge clk) s = 0;
      @(negedge clk);
   endtask
   task automatic vs(input logic [14:0] p, input logic [6:0] e, d,
      input logic [7:0] s);
      logic [6:0] g;
      g = p[14:8] + (p[7:0] == 8'hFF);
      instr_pc = p;
      src_enable = e;
      src_pending = d;
      vector_select_instruction = 1;
      @(negedge clk) vector_select_instruction = 0;
      chk("busy", busy, 15'h1);
      wt();
      chk("pc", pc_value, {s[6:0] ^ g, (s + 8'h01) ^ {1'b0, g}});
      chk("idle", busy, 15'h0);
   endtask
   task automatic stop_test();
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      repeat (3) @(negedge clk);
      chk("trap", trap_pending, 15'h0);
      foreach (rows[i]) vs(rows[i][36:22], rows[i][21:15], rows[i][14:8],
         rows[i][7:0]);
      pulse(trap_opcode);
      vs(15'h02FF, '1, '1, 8'hFE);
      pulse(clear_trap_pending_instruction);
      chk("trap", trap_pending, 15'h0);
      pulse(gie_set);
      chk("gie set", global_interrupt_enable, 15'h1);
      instr_pc = 15'h0345;
      irq_ack = 1;
      @(negedge clk) irq_ack = 0;
      chk("push", push_addr, 15'h0345);
      chk("gie", global_interrupt_enable, 15'h0);
      wt();
      chk("ack pc", pc_value, 15'h00FF);
      trap_opcode = 1;
      clear_trap_pending_instruction = 1;
      gie_set = 1;
      @(negedge clk) trap_opcode = 0;
      clear_trap_pending_instruction = 0;
      gie_set = 0;
      @(negedge clk);
      chk("set wins", trap_pending, 15'h1);
      rst_n = 0;
      @(negedge clk) rst_n = 1;
      repeat (3) @(negedge clk);
      chk("reset trap", trap_pending, 15'h0);
      chk("reset gie", global_interrupt_enable, 15'h0);
      stop_test();
   end
endmodule
